// ---- pwr_seq_consts.svh ----
// Timing counts and code values for the power mode reset sequencer
`ifndef PWR_SEQ_CONSTS_SVH
`define PWR_SEQ_CONSTS_SVH
`define CLK_FREQ_HZ 100000000
`define WDT_WARN_S 2
`define WDT_RESET_S 4
`define WDT_WARN_CYC (`WDT_WARN_S * `CLK_FREQ_HZ)
`define WDT_RESET_CYC (`WDT_RESET_S * `CLK_FREQ_HZ)
`define WDT_CNT_W 32
`define WAKE_CAUSE_NONE 2'h0
`define WAKE_CAUSE_TIMER 2'h1
`define WAKE_CAUSE_GPIO 2'h2
`define WAKE_CNT_W 32
`endif

// ---- pwr_seq_pkg.sv ----
// Types for the power mode reset sequencer
package pwr_seq_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_BUCK = 4'h1,
    ST_LDO = 4'h3,
    ST_ACTIVE = 4'h2,
    ST_IDLE = 4'h6,
    ST_SLEEP = 4'h7,
    ST_RETAIN = 4'h5,
    ST_EXT_PD = 4'h4,
    ST_DEEP_OFF = 4'hc,
    ST_SHUTDOWN = 4'hd
  } pwr_state_t;

  typedef enum logic [2:0] {
    REQ_NONE = 3'h0,
    REQ_IDLE = 3'h1,
    REQ_SLEEP = 3'h2,
    REQ_RETAIN = 3'h3,
    REQ_EXT_PD = 3'h4,
    REQ_DEEP_OFF = 3'h5,
    REQ_ACTIVE = 3'h6
  } mode_req_t;

  typedef struct packed {
    logic buck_en;
    logic radio_ldo_en;
    logic dig_ldo_en;
    logic core_rst_n;
    logic cpu_run;
    logic cpu_halt_wait;
    logic bus_clk_en;
    logic periph_clk_en;
    logic low_power_oscillator_en;
    logic ldo_low_v;
    logic ram_ret;
    logic core_logic_pwr;
    logic gpio_dom_pwr;
  } pwr_ctrl_t;
endpackage

// ---- wake_timer.sv ----
// Programmable wake period counter on the low-power oscillator tick
`timescale 1ns/1ps
module wake_timer #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [W-1:0] period_i,
  output logic expired_o
);
  logic [W-1:0] cnt_r;

  // Counts ticks while armed, flags on reaching the period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_r <= '0;
      expired_o <= 1'b0;
    end else if (tick_i && !expired_o) begin
      cnt_r <= cnt_r + 1'b1;
      if (cnt_r + 1'b1 >= period_i) begin
        expired_o <= 1'b1;
      end
    end
  end
endmodule

// ---- watchdog.sv ----
// Inactivity watchdog with early warning and reset stages
`timescale 1ns/1ps
module watchdog #(
  parameter int unsigned WARN_CYC = 200000000,
  parameter int unsigned RESET_CYC = 400000000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic kick_i,
  output logic warn_o,
  output logic bite_o
);
  logic [31:0] cnt_r;

  // Counts inactivity, kick restarts from zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !enable_i || kick_i) begin
      cnt_r <= '0;
      warn_o <= 1'b0;
      bite_o <= 1'b0;
    end else begin
      if (cnt_r < RESET_CYC) begin
        cnt_r <= cnt_r + 32'h1;
      end
      if (cnt_r + 32'h1 >= WARN_CYC) begin
        warn_o <= 1'b1;
      end
      bite_o <= (cnt_r + 32'h1 >= RESET_CYC);
    end
  end
endmodule

// ---- power_mode_reset_sequencer.sv ----
// Power-up sequencing, power mode control and watchdog supervision
// Contract
// - Watchdog raises firmware interrupt after 2 s unserviced.
// - Watchdog resets the whole device after 4 s unserviced; the bite keeps WOKE_FROM_DEEP_OFF_O and WAKE_CAUSE_O.
// - After supply and reset release, enable buck, then radio and digital regulators.
// - Hold core reset until regulators report stable, then release.
// - External reset accepted at any time after power-up.
// - Brownout forces the device into shutdown.
// - Active mode: all peripherals clocked, processor running.
// - Idle mode: processor paused, rest of system operating.
// - Sleep: only low-power oscillator runs, bus clock stopped, processor halt-waits.
// - Sleep wakes on timer expiry or GPIO event.
// - Sleep keeps state and SRAM, regulators at reduced voltage.
// - Retention mode: radio and core off, RAM, registers kept; timer or GPIO wake.
// - Extended power-down keeps main RAM and control only; timer or event wake.
// - Deep-off keeps only GPIO domain; GPIO or timer wake.
// - Timed deep-off keeps oscillator running; event-only wake lets clocks stop.
// - After deep-off wake, full init but keep deep-off and cause indicators.
// - External reset gives the same known state as power-on reset.
`timescale 1ns/1ps
`include "pwr_seq_consts.svh"
module power_mode_reset_sequencer #(
  parameter int unsigned WDT_WARN_CYC = `WDT_WARN_CYC,
  parameter int unsigned WDT_RESET_CYC = `WDT_RESET_CYC,
  parameter int WAKE_W = `WAKE_CNT_W
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic SUPPLY_OK_I,
  input wire logic EXTERNAL_RESET_N_I,
  input wire logic BROWNOUT_I,
  input wire logic BUCK_STABLE_I,
  input wire logic LDO_STABLE_I,
  input wire pwr_seq_pkg::mode_req_t MODE_REQ_I,
  input wire logic TIMED_WAKE_EN_I,
  input wire logic [WAKE_W-1:0] WAKE_PERIOD_I,
  input wire logic LPO_TICK_I,
  input wire logic GPIO_WAKE_I,
  input wire logic WDT_EN_I,
  input wire logic WDT_KICK_I,
  input wire logic DEEP_OFF_FLAG_CLR_I,
  output pwr_seq_pkg::pwr_ctrl_t PWR_CTRL_O,
  output pwr_seq_pkg::pwr_state_t STATE_O,
  output logic WDT_IRQ_O,
  output logic WDT_RESET_O,
  output logic WOKE_FROM_DEEP_OFF_O,
  output logic [1:0] WAKE_CAUSE_O
);
  pwr_seq_pkg::pwr_state_t state_r;
  pwr_seq_pkg::pwr_state_t state_nxt;
  pwr_seq_pkg::pwr_ctrl_t ctrl_nxt;
  logic timer_run;
  logic timer_expired;
  logic wdt_warn;
  logic wdt_bite;
  logic low_power;
  logic wake;
  logic deep_timed_r;
  logic hard_rst;
  logic ext_rst;
  logic wdt_run;
  logic deep_wake;

  // Any source of full reset returns the state, wake timer and power controls to the power-on state
  assign hard_rst = !RST_N_I || !EXTERNAL_RESET_N_I || wdt_bite;

  // Power-on or pin reset, without the watchdog bite
  assign ext_rst = !RST_N_I || !EXTERNAL_RESET_N_I;

  // Modes that wait for a timer or GPIO wake
  assign low_power = (state_r == pwr_seq_pkg::ST_SLEEP) ||
                     (state_r == pwr_seq_pkg::ST_RETAIN) ||
                     (state_r == pwr_seq_pkg::ST_EXT_PD) ||
                     (state_r == pwr_seq_pkg::ST_DEEP_OFF);

  // Wake timer armed only in low-power modes with timed wake chosen
  assign timer_run = low_power && TIMED_WAKE_EN_I;

  // Watchdog runs only while the processor is powered and clocked
  assign wdt_run = WDT_EN_I && (state_r == pwr_seq_pkg::ST_ACTIVE ||
                                state_r == pwr_seq_pkg::ST_IDLE);

  // Wake period counter on oscillator ticks
  wake_timer #(
    .W(WAKE_W)
  ) u_wake_timer (
    .clk_i(SYS_CLK_I),
    .rst_n_i(!hard_rst),
    .run_i(timer_run),
    .tick_i(LPO_TICK_I),
    .period_i(WAKE_PERIOD_I),
    .expired_o(timer_expired)
  );

  // Inactivity watchdog
  watchdog #(
    .WARN_CYC(WDT_WARN_CYC),
    .RESET_CYC(WDT_RESET_CYC)
  ) u_watchdog (
    .clk_i(SYS_CLK_I),
    .rst_n_i(!ext_rst),
    .enable_i(wdt_run),
    .kick_i(WDT_KICK_I),
    .warn_o(wdt_warn),
    .bite_o(wdt_bite)
  );

  // Wake from timer or GPIO in any low-power mode
  assign wake = low_power && (timer_expired || GPIO_WAKE_I);

  // Wake out of deep-off, recorded for firmware
  assign deep_wake = (state_r == pwr_seq_pkg::ST_DEEP_OFF) && wake;

  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Wait for supply before starting the regulators
      pwr_seq_pkg::ST_OFF: begin
        if (SUPPLY_OK_I && !BROWNOUT_I) begin
          state_nxt = pwr_seq_pkg::ST_BUCK;
        end
      end

      // Buck first, regulators after it settles
      pwr_seq_pkg::ST_BUCK: begin
        if (BUCK_STABLE_I) begin
          state_nxt = pwr_seq_pkg::ST_LDO;
        end
      end

      // Core reset held until the regulators settle
      pwr_seq_pkg::ST_LDO: begin
        if (LDO_STABLE_I) begin
          state_nxt = pwr_seq_pkg::ST_ACTIVE;
        end
      end

      // Firmware picks the next mode
      pwr_seq_pkg::ST_ACTIVE: begin
        case (MODE_REQ_I)
          pwr_seq_pkg::REQ_IDLE: state_nxt = pwr_seq_pkg::ST_IDLE;
          pwr_seq_pkg::REQ_SLEEP: state_nxt = pwr_seq_pkg::ST_SLEEP;
          pwr_seq_pkg::REQ_RETAIN: state_nxt = pwr_seq_pkg::ST_RETAIN;
          pwr_seq_pkg::REQ_EXT_PD: state_nxt = pwr_seq_pkg::ST_EXT_PD;
          pwr_seq_pkg::REQ_DEEP_OFF: state_nxt = pwr_seq_pkg::ST_DEEP_OFF;
          default: state_nxt = pwr_seq_pkg::ST_ACTIVE;
        endcase
      end

      // Paused processor resumes on request or GPIO
      pwr_seq_pkg::ST_IDLE: begin
        if (MODE_REQ_I == pwr_seq_pkg::REQ_ACTIVE || GPIO_WAKE_I) begin
          state_nxt = pwr_seq_pkg::ST_ACTIVE;
        end
      end

      // Sleep keeps the regulators, so straight back
      pwr_seq_pkg::ST_SLEEP: begin
        if (wake) begin
          state_nxt = pwr_seq_pkg::ST_ACTIVE;
        end
      end

      // Regulators were off, so restart them first
      pwr_seq_pkg::ST_RETAIN, pwr_seq_pkg::ST_EXT_PD: begin
        if (wake) begin
          state_nxt = pwr_seq_pkg::ST_LDO;
        end
      end

      // Everything was off, so rerun the full sequence
      pwr_seq_pkg::ST_DEEP_OFF: begin
        if (wake) begin
          state_nxt = pwr_seq_pkg::ST_BUCK;
        end
      end

      // Leave shutdown once the supply recovers
      pwr_seq_pkg::ST_SHUTDOWN: begin
        if (!BROWNOUT_I) begin
          state_nxt = pwr_seq_pkg::ST_OFF;
        end
      end

      // Unused codes fall back to off
      default: state_nxt = pwr_seq_pkg::ST_OFF;
    endcase
    if (BROWNOUT_I) begin
      state_nxt = pwr_seq_pkg::ST_SHUTDOWN;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK_I) begin
    if (hard_rst) begin
      state_r <= pwr_seq_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remembers whether deep-off was entered with timed wake
  always_ff @(posedge SYS_CLK_I) begin
    if (hard_rst) begin
      deep_timed_r <= 1'b0;
    end else if (state_r == pwr_seq_pkg::ST_ACTIVE) begin
      deep_timed_r <= TIMED_WAKE_EN_I;
    end
  end

  // Deep-off wake indicators survive the re-initialisation
  always_ff @(posedge SYS_CLK_I) begin
    if (ext_rst) begin
      WOKE_FROM_DEEP_OFF_O <= 1'b0;
      WAKE_CAUSE_O <= `WAKE_CAUSE_NONE;
    end else if (deep_wake) begin
      WOKE_FROM_DEEP_OFF_O <= 1'b1;
      WAKE_CAUSE_O <= GPIO_WAKE_I ? `WAKE_CAUSE_GPIO : `WAKE_CAUSE_TIMER;
    end else if (DEEP_OFF_FLAG_CLR_I) begin
      WOKE_FROM_DEEP_OFF_O <= 1'b0;
      WAKE_CAUSE_O <= `WAKE_CAUSE_NONE;
    end
  end

  // Power and clock controls decoded from the next state
  always_comb begin
    ctrl_nxt = '0;
    case (state_nxt)
      // Buck only, core still in reset
      pwr_seq_pkg::ST_BUCK: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.core_logic_pwr = 1'b1;
      end

      // Radio and digital regulators follow the buck
      pwr_seq_pkg::ST_LDO: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.radio_ldo_en = 1'b1;
        ctrl_nxt.dig_ldo_en = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.core_logic_pwr = 1'b1;
      end

      // Full power; idle only stops the processor
      pwr_seq_pkg::ST_ACTIVE, pwr_seq_pkg::ST_IDLE: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.radio_ldo_en = 1'b1;
        ctrl_nxt.dig_ldo_en = 1'b1;
        ctrl_nxt.core_rst_n = 1'b1;
        ctrl_nxt.cpu_run = (state_nxt == pwr_seq_pkg::ST_ACTIVE);
        ctrl_nxt.bus_clk_en = 1'b1;
        ctrl_nxt.periph_clk_en = 1'b1;
        ctrl_nxt.low_power_oscillator_en = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.core_logic_pwr = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
      end

      // Bus clock stopped, regulators at reduced voltage
      pwr_seq_pkg::ST_SLEEP: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.radio_ldo_en = 1'b1;
        ctrl_nxt.dig_ldo_en = 1'b1;
        ctrl_nxt.core_rst_n = 1'b1;
        ctrl_nxt.cpu_halt_wait = 1'b1;
        ctrl_nxt.low_power_oscillator_en = 1'b1;
        ctrl_nxt.ldo_low_v = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.core_logic_pwr = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
      end

      // Radio and regulators off, RAM and some logic kept
      pwr_seq_pkg::ST_RETAIN: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.low_power_oscillator_en = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.core_logic_pwr = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
      end

      // Only main RAM and its control kept
      pwr_seq_pkg::ST_EXT_PD: begin
        ctrl_nxt.buck_en = 1'b1;
        ctrl_nxt.low_power_oscillator_en = 1'b1;
        ctrl_nxt.ram_ret = 1'b1;
        ctrl_nxt.gpio_dom_pwr = 1'b1;
      end

      // GPIO domain only; oscillator kept for timed wake
      pwr_seq_pkg::ST_DEEP_OFF: begin
        ctrl_nxt.gpio_dom_pwr = 1'b1;
        ctrl_nxt.low_power_oscillator_en = (state_r == pwr_seq_pkg::ST_DEEP_OFF) ?
                                           deep_timed_r : TIMED_WAKE_EN_I;
      end

      // Everything off until supply returns
      pwr_seq_pkg::ST_OFF, pwr_seq_pkg::ST_SHUTDOWN: begin
        ctrl_nxt = '0;
      end

      default: ctrl_nxt = '0;
    endcase
  end

  // Registered power and clock controls
  always_ff @(posedge SYS_CLK_I) begin
    if (hard_rst) begin
      PWR_CTRL_O <= '0;
    end else begin
      PWR_CTRL_O <= ctrl_nxt;
    end
  end

  // Watchdog early warning, dropped at once on a service
  always_ff @(posedge SYS_CLK_I) begin
    if (ext_rst) begin
      WDT_IRQ_O <= 1'b0;
    end else begin
      WDT_IRQ_O <= wdt_warn && !WDT_KICK_I;
    end
  end

  // Watchdog reset indication
  always_ff @(posedge SYS_CLK_I) begin
    if (ext_rst) begin
      WDT_RESET_O <= 1'b0;
    end else begin
      WDT_RESET_O <= wdt_bite;
    end
  end

  // Current mode for firmware
  assign STATE_O = state_r;
endmodule

// ---- power_seq_chk.sv ----
// Port assertions for the power mode reset sequencer
`timescale 1ns/1ps
module power_seq_chk #(
  parameter int unsigned WDT_WARN_CYC = 20,
  parameter int unsigned WDT_RESET_CYC = 40
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic EXTERNAL_RESET_N_I,
  input wire logic BROWNOUT_I,
  input wire logic BUCK_STABLE_I,
  input wire logic GPIO_WAKE_I,
  input wire logic WDT_EN_I,
  input wire logic WDT_KICK_I,
  input wire pwr_seq_pkg::pwr_ctrl_t PWR_CTRL_O,
  input wire pwr_seq_pkg::pwr_state_t STATE_O,
  input wire logic WDT_IRQ_O,
  input wire logic WDT_RESET_O
);
  logic [31:0] wcnt_r;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Cycles the watchdog has run unserviced
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || !EXTERNAL_RESET_N_I || WDT_KICK_I || !WDT_EN_I || WDT_RESET_O) begin
      wcnt_r <= 32'h0;
    end else if (STATE_O == pwr_seq_pkg::ST_ACTIVE || STATE_O == pwr_seq_pkg::ST_IDLE) begin
      wcnt_r <= wcnt_r + 32'h1;
    end else begin
      wcnt_r <= 32'h0;
    end
  end
  property p_ldo;
    STATE_O == pwr_seq_pkg::ST_BUCK && BUCK_STABLE_I && !BROWNOUT_I && EXTERNAL_RESET_N_I
      |=> STATE_O == pwr_seq_pkg::ST_LDO && PWR_CTRL_O.buck_en && !PWR_CTRL_O.core_rst_n;
  endproperty
  a_ldo: assert property (p_ldo) else $error("regulator step wrong");
  property p_brown;
    BROWNOUT_I |=> STATE_O == pwr_seq_pkg::ST_SHUTDOWN;
  endproperty
  a_brown: assert property (p_brown) else $error("no shutdown");
  property p_act;
    STATE_O == pwr_seq_pkg::ST_ACTIVE |-> PWR_CTRL_O.cpu_run && PWR_CTRL_O.periph_clk_en
      && PWR_CTRL_O.bus_clk_en && PWR_CTRL_O.core_rst_n;
  endproperty
  a_act: assert property (p_act) else $error("active controls wrong");
  property p_sleep;
    STATE_O == pwr_seq_pkg::ST_SLEEP |-> PWR_CTRL_O.cpu_halt_wait && !PWR_CTRL_O.bus_clk_en
      && PWR_CTRL_O.low_power_oscillator_en && PWR_CTRL_O.ldo_low_v && PWR_CTRL_O.ram_ret;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep controls wrong");
  property p_wake;
    STATE_O == pwr_seq_pkg::ST_SLEEP && GPIO_WAKE_I && !BROWNOUT_I && EXTERNAL_RESET_N_I
      |=> STATE_O == pwr_seq_pkg::ST_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_irq;
    $rose(WDT_IRQ_O) |-> wcnt_r + 32'h3 >= WDT_WARN_CYC && wcnt_r <= WDT_WARN_CYC + 3;
  endproperty
  a_irq: assert property (p_irq) else $error("warning mistimed");
  property p_kick;
    WDT_KICK_I && STATE_O == pwr_seq_pkg::ST_ACTIVE |=> !WDT_IRQ_O;
  endproperty
  a_kick: assert property (p_kick) else $error("warning not cleared");
  property p_bite;
    $rose(WDT_RESET_O) |-> wcnt_r + 32'h3 >= WDT_RESET_CYC && wcnt_r <= WDT_RESET_CYC + 3
      ##[0:2] STATE_O == pwr_seq_pkg::ST_OFF;
  endproperty
  a_bite: assert property (p_bite) else $error("bite wrong");
  c_sleep: cover property (STATE_O == pwr_seq_pkg::ST_SLEEP && GPIO_WAKE_I);
  c_brown: cover property ($rose(STATE_O == pwr_seq_pkg::ST_SHUTDOWN));
  c_bite: cover property ($rose(WDT_RESET_O));
endmodule
bind power_mode_reset_sequencer power_seq_chk #(.WDT_WARN_CYC(WDT_WARN_CYC),
  .WDT_RESET_CYC(WDT_RESET_CYC)) power_seq_chk_i (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .EXTERNAL_RESET_N_I(EXTERNAL_RESET_N_I), .BROWNOUT_I(BROWNOUT_I),
  .BUCK_STABLE_I(BUCK_STABLE_I), .GPIO_WAKE_I(GPIO_WAKE_I), .WDT_EN_I(WDT_EN_I),
  .WDT_KICK_I(WDT_KICK_I), .PWR_CTRL_O(PWR_CTRL_O), .STATE_O(STATE_O),
  .WDT_IRQ_O(WDT_IRQ_O), .WDT_RESET_O(WDT_RESET_O));

// ---- reg_lpo_model.sv ----
// Regulator and low-power oscillator model facing the sequencer
`timescale 1ns/1ps
module reg_lpo_model #(
  parameter int DLY = 3,
  parameter int LPO_DIV = 8
) (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic buck_en_i,
  input wire logic ldo_en_i,
  input wire logic osc_en_i,
  output logic buck_stable_o,
  output logic ldo_stable_o,
  output logic tick_o
);
  int bc = 0, lc = 0, tc = 0;
  // Settling counters; oscillator stops when not enabled
  always @(posedge clk_i) begin
    bc <= buck_en_i ? bc + 1 : 0;
    lc <= ldo_en_i ? lc + 1 : 0;
    tc <= osc_en_i ? (tc + 1) % LPO_DIV : 0;
  end
  assign buck_stable_o = bc > (slow_i ? 4 * DLY : DLY);
  assign ldo_stable_o = lc > (slow_i ? 4 * DLY : DLY);
  assign tick_o = osc_en_i && tc == LPO_DIV - 1;
endmodule

// ---- testbench.sv ----
// Self-checking bench for the power mode reset sequencer
`timescale 1ns/1ps
`include "pwr_seq_consts.svh"
module testbench;
  localparam int WARN = 20;
  localparam int BITE = 40;
  logic clk, rst_n = 0, sup = 0, xrst_n = 1, bo = 0, ten = 0, gpio = 0;
  logic wen = 0, kick = 0, fclr = 0, slow = 0, ut, bs, ls, tick, irq, bite, woke;
  logic [31:0] period = 32'h1;
  logic [1:0] cause;
  pwr_seq_pkg::mode_req_t req = pwr_seq_pkg::REQ_NONE, r;
  pwr_seq_pkg::pwr_ctrl_t ctrl;
  pwr_seq_pkg::pwr_state_t st;
  int bad_count = 0, check_count = 0, seed = 61479, n;

  // 100 MHz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  power_mode_reset_sequencer #(.WDT_WARN_CYC(WARN), .WDT_RESET_CYC(BITE))
    power_mode_reset_sequencer_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SUPPLY_OK_I(sup),
    .EXTERNAL_RESET_N_I(xrst_n), .BROWNOUT_I(bo), .BUCK_STABLE_I(bs), .LDO_STABLE_I(ls),
    .MODE_REQ_I(req), .TIMED_WAKE_EN_I(ten), .WAKE_PERIOD_I(period), .LPO_TICK_I(tick),
    .GPIO_WAKE_I(gpio), .WDT_EN_I(wen), .WDT_KICK_I(kick), .DEEP_OFF_FLAG_CLR_I(fclr),
    .PWR_CTRL_O(ctrl), .STATE_O(st), .WDT_IRQ_O(irq), .WDT_RESET_O(bite),
    .WOKE_FROM_DEEP_OFF_O(woke), .WAKE_CAUSE_O(cause));

  reg_lpo_model reg_lpo_model_i (.clk_i(clk), .slow_i(slow), .buck_en_i(ctrl.buck_en),
    .ldo_en_i(ctrl.radio_ldo_en & ctrl.dig_ldo_en), .osc_en_i(ctrl.low_power_oscillator_en),
    .buck_stable_o(bs), .ldo_stable_o(ls), .tick_o(tick));

  // Drive just after the rising edge
  task step();
    @(posedge clk);
    #1;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a state, then compare
  task wait_st(input pwr_seq_pkg::pwr_state_t s);
    n = 0;
    while (st !== s && n < 300) begin
      step();
      n++;
    end
    chk(16'(st), 16'(s));
  endtask

  function automatic pwr_seq_pkg::pwr_state_t exp_st(input pwr_seq_pkg::mode_req_t q);
    case (q)
      pwr_seq_pkg::REQ_IDLE: return pwr_seq_pkg::ST_IDLE;
      pwr_seq_pkg::REQ_SLEEP: return pwr_seq_pkg::ST_SLEEP;
      pwr_seq_pkg::REQ_RETAIN: return pwr_seq_pkg::ST_RETAIN;
      pwr_seq_pkg::REQ_EXT_PD: return pwr_seq_pkg::ST_EXT_PD;
      default: return pwr_seq_pkg::ST_DEEP_OFF;
    endcase
  endfunction

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) step();
    rst_n = 1;
    sup = 1;
    wait_st(pwr_seq_pkg::ST_ACTIVE);
    chk(16'(ctrl.core_rst_n), 16'h1);
    for (int k = 0; k < 10; k++) begin
      r = pwr_seq_pkg::mode_req_t'(3'(k % 5 + 1));
      ut = 1'($random(seed));
      slow = (k >= 5);
      ten = ut;
      period = 32'($random(seed) & 3) + 32'h1;
      req = r;
      step();
      req = pwr_seq_pkg::REQ_NONE;
      chk(16'(st), 16'(exp_st(r)));
      if (r == pwr_seq_pkg::REQ_IDLE) chk(16'(ctrl.cpu_run), 16'h0);
      if (r == pwr_seq_pkg::REQ_DEEP_OFF)
        chk(16'({ctrl.buck_en, ctrl.low_power_oscillator_en}), 16'({1'b0, ut}));
      if (!ut) gpio = 1;
      else if (r == pwr_seq_pkg::REQ_IDLE) req = pwr_seq_pkg::REQ_ACTIVE;
      step();
      gpio = 0;
      req = pwr_seq_pkg::REQ_NONE;
      wait_st(pwr_seq_pkg::ST_ACTIVE);
      ten = 0;
      if (r == pwr_seq_pkg::REQ_DEEP_OFF) begin
        chk(16'(woke), 16'h1);
        chk(16'(cause), ut ? 16'(`WAKE_CAUSE_TIMER) : 16'(`WAKE_CAUSE_GPIO));
        fclr = 1;
        step();
        fclr = 0;
        chk(16'(woke), 16'h0);
      end
    end
    xrst_n = 0;
    step();
    step();
    chk(16'(st), 16'(pwr_seq_pkg::ST_OFF));
    chk(16'(ctrl), 16'h0);
    xrst_n = 1;
    wait_st(pwr_seq_pkg::ST_ACTIVE);
    bo = 1;
    step();
    bo = 0;
    chk(16'(st), 16'(pwr_seq_pkg::ST_SHUTDOWN));
    rst_n = 0;
    step();
    rst_n = 1;
    wait_st(pwr_seq_pkg::ST_ACTIVE);
    wen = 1;
    repeat (8) begin
      repeat (2 + ($random(seed) & 7)) step();
      kick = 1;
      step();
      kick = 0;
      chk(16'(irq), 16'h0);
    end
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    chk(16'(n >= WARN - 1 && n <= WARN + 3), 16'h1);
    kick = 1;
    step();
    kick = 0;
    chk(16'(irq), 16'h0);
    n = 0;
    while (bite !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    chk(16'(n >= BITE - 1 && n <= BITE + 3), 16'h1);
    finish_test();
  end

  // Hang guard
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
endmodule
